// [rtl/bank_rw_core.sv]
// Command decode, bank tracking and burst data paths of a low-power DDR memory core.
// Assumes a controller drives the command bus on clk and the strobes on link_clk.
//
// Functional notes
// - Activate decodes on select low, CA0 low, CA1 high; bank and row taken.
// - Reads or writes need an open bank and tRCD elapsed since activate.
// - Column access on CA0 high, CA1 low; CA2 high reads, low writes.
// - Each column command runs a whole burst on successive cycles, uninterrupted; a write start mid-capture restarts it, dropping the earlier write.
// - Start column comes from rising CA5-CA6 and falling CA2-CA9.
// - Read data first valid RL cycles plus strobe delays after command.
// - Read strobe held low for preamble, first bit on first rising edge.
// - Reads every fourth clock give gapless bursts of eight; the core chains at most two reads per read frame.
// - Read strobe delay drift stays within long, medium and short bounds.
// - Write data is sampled on successive strobe edges until burst complete.
// - One mask bit per byte per beat blocks writing that byte.
`timescale 1ns/1ps
module bank_rw_core (
    // Core clock and reset.
    input wire logic clk,
    input wire logic rst_b,
    // Command and address bus; CA sampled on both clock edges, select on the rising edge only.
    input wire logic cs_b,
    input wire logic [bank_rw_pkg::CA_W-1:0] ca,
    // Link clock for the strobe-side data path.
    input wire logic link_clk,
    // Data strobe and data pins; data split into in, out and enable, mask in only, strobe out and enable.
    input wire logic [bank_rw_pkg::DQ_W-1:0] dq_in,
    output logic [bank_rw_pkg::DQ_W-1:0] dq_out,
    output logic dq_oe,
    input wire logic [bank_rw_pkg::BYTES-1:0] dm_in,
    output logic dqs_out,
    output logic dqs_oe,
    // Status toward the surrounding chip.
    output logic [bank_rw_pkg::NUM_BANKS-1:0] bank_open,
    output logic cmd_error,
    output logic [bank_rw_pkg::DQ_W-1:0] mem_rd_word
);

    typedef enum logic [1:0] {IDLE, PRE, BURST} rd_state_e;

    // Falling-edge capture of the command bus for row and column bits.
    logic [bank_rw_pkg::CA_W-1:0] ca_fall_q;
    always_ff @(negedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ca_fall_q <= '0;
        end else begin
            ca_fall_q <= ca;
        end
    end

    // Rising-edge command register; falling bits follow half a cycle later.
    logic cs_b_q;
    logic [bank_rw_pkg::CA_W-1:0] ca_rise_q;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cs_b_q <= 1'b1;
            ca_rise_q <= '0;
        end else begin
            cs_b_q <= cs_b;
            ca_rise_q <= ca;
        end
    end

    // Command decode, evaluated once both halves of the command are held.
    // activate decode.
    wire is_act = !cs_b_q && !ca_rise_q[bank_rw_pkg::CA_BIT0] && ca_rise_q[bank_rw_pkg::CA_BIT1];
    wire is_col = !cs_b_q && ca_rise_q[bank_rw_pkg::CA_BIT0] && !ca_rise_q[bank_rw_pkg::CA_BIT1];
    wire is_rd = is_col && ca_rise_q[bank_rw_pkg::CA_BIT2];
    wire is_wr = is_col && !ca_rise_q[bank_rw_pkg::CA_BIT2];
    wire [bank_rw_pkg::BANK_W-1:0] cmd_bank = ca_rise_q[9:7];
    // Row is split across both halves; the low rise bits carry the upper row bits.
    wire [bank_rw_pkg::ROW_W-1:0] act_row = {ca_rise_q[6:2], ca_fall_q};
    // start column.
    // The two lowest falling bits only select a beat inside the burst, which the small array never needs.
    wire [bank_rw_pkg::COL_W-1:0] col_addr = {ca_rise_q[6:5], ca_fall_q[9:2]};

    // Per-bank open flag, open row and tRCD countdown.
    logic [bank_rw_pkg::ROW_W-1:0] open_row_q [bank_rw_pkg::NUM_BANKS];
    logic [3:0] rcd_cnt_q [bank_rw_pkg::NUM_BANKS];
    logic [bank_rw_pkg::NUM_BANKS-1:0] open_q;
    genvar b;
    generate
        for (b = 0; b < bank_rw_pkg::NUM_BANKS; b++) begin : g_bank
            wire hit = cmd_bank == bank_rw_pkg::BANK_W'(b);
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    open_q[b] <= 1'b0;
                    open_row_q[b] <= '0;
                    rcd_cnt_q[b] <= '0;
                end else if (is_act && hit) begin
                    open_q[b] <= 1'b1;
                    open_row_q[b] <= act_row;
                    rcd_cnt_q[b] <= 4'(bank_rw_pkg::T_RCD_CYC);
                end else if (rcd_cnt_q[b] != 4'h0) begin
                    rcd_cnt_q[b] <= rcd_cnt_q[b] - 4'h1;
                end
            end
        end
    endgenerate
    assign bank_open = open_q;

    wire col_ok = open_q[cmd_bank] && (rcd_cnt_q[cmd_bank] <= 4'h1);
    wire rd_go = is_rd && col_ok;
    wire wr_go = is_wr && col_ok;

    // Flag a rejected column command; held until the next accepted one.
    // A refused command launches nothing, so no stale data ever reaches the pins.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cmd_error <= 1'b0;
        end else if (is_col) begin
            cmd_error <= !col_ok;
        end
    end

    // Small array indexed by bank bit 0, bit 0 of the open row and column bits 4:3.
    logic [bank_rw_pkg::DQ_W-1:0] mem_q [bank_rw_pkg::ROW_MEM_DEPTH];
    wire [bank_rw_pkg::MEM_IDX_W-1:0] cmd_idx = {cmd_bank[0], open_row_q[cmd_bank][0], col_addr[4:3]};

    // read burst launch queue; RL slots deep, one per cycle.
    logic [bank_rw_pkg::READ_LAT-1:0] rl_pipe_q;
    logic [bank_rw_pkg::MEM_IDX_W-1:0] rd_idx_q [bank_rw_pkg::READ_LAT];
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rl_pipe_q <= '0;
        end else begin
            rl_pipe_q <= {rl_pipe_q[bank_rw_pkg::READ_LAT-2:0], rd_go};
        end
    end
    generate
        for (b = 0; b < bank_rw_pkg::READ_LAT; b++) begin : g_rdidx
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    rd_idx_q[b] <= '0;
                end else begin
                    rd_idx_q[b] <= (b == 0) ? cmd_idx : rd_idx_q[(b == 0) ? 0 : b-1];
                end
            end
        end
    endgenerate

    // Read word handed to the link side; held until the next read launch.
    wire rd_launch = rl_pipe_q[bank_rw_pkg::READ_LAT-1];
    logic rd_tog_q;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_tog_q <= 1'b0;
            mem_rd_word <= '0;
        end else if (rd_launch) begin
            rd_tog_q <= !rd_tog_q;
            mem_rd_word <= mem_q[rd_idx_q[bank_rw_pkg::READ_LAT-1]];
        end
    end

    // Write latency line; the link side opens its capture window from it.
    logic [bank_rw_pkg::WRITE_LAT-1:0] wl_pipe_q;
    logic [bank_rw_pkg::MEM_IDX_W-1:0] wr_idx_q;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wl_pipe_q <= '0;
            wr_idx_q <= '0;
        end else begin
            wl_pipe_q <= {wl_pipe_q[bank_rw_pkg::WRITE_LAT-2:0], wr_go};
            if (wr_go) begin
                wr_idx_q <= cmd_idx;
            end
        end
    end
    logic wr_tog_q;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_tog_q <= 1'b0;
        end else if (wl_pipe_q[bank_rw_pkg::WRITE_LAT-1]) begin
            wr_tog_q <= !wr_tog_q;
        end
    end

    // Link domain: toggles from the core pass two flops first.
    logic [2:0] rd_sync_q;
    logic [2:0] wr_sync_q;
    always_ff @(posedge link_clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_sync_q <= '0;
            wr_sync_q <= '0;
        end else begin
            rd_sync_q <= {rd_sync_q[1:0], rd_tog_q};
            wr_sync_q <= {wr_sync_q[1:0], wr_tog_q};
        end
    end
    wire rd_start = rd_sync_q[2] ^ rd_sync_q[1];
    wire wr_start = wr_sync_q[2] ^ wr_sync_q[1];

    // Read drive: one preamble cycle with strobe low, then eight beats.
    // preamble then aligned beats.
    // a new start during the last beat chains seamlessly.
    rd_state_e rd_st_q;
    logic [2:0] beat_q;
    logic [bank_rw_pkg::DQ_W-1:0] rd_word_q;
    logic rd_pend_q;
    wire last_beat = beat_q == 3'h7;
    // A frame on the link lasts longer than the read spacing, so a start that
    // lands mid-frame waits in rd_pend_q and chains at the last beat.
    wire rd_chain = (rd_st_q == BURST) && last_beat && (rd_start || rd_pend_q);
    always_ff @(posedge link_clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_st_q <= IDLE;
            beat_q <= '0;
            rd_word_q <= '0;
        end else begin
            unique case (rd_st_q)
                IDLE: if (rd_start) begin
                    rd_st_q <= PRE;
                    rd_word_q <= mem_rd_word;
                end
                PRE: begin
                    rd_st_q <= BURST;
                    beat_q <= '0;
                end
                BURST: begin
                    beat_q <= beat_q + 3'h1;
                    if (last_beat) begin
                        rd_st_q <= rd_chain ? BURST : IDLE;
                        if (rd_chain) begin
                            rd_word_q <= mem_rd_word;
                        end
                    end
                end
            endcase
        end
    end

    // One start can wait; a third read inside one frame overwrites the launched
    // word, so the controller is limited to two reads per frame at this link rate.
    // pending start for gapless reads.
    always_ff @(posedge link_clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_pend_q <= 1'b0;
        end else if (rd_start && (rd_st_q != IDLE)) begin
            rd_pend_q <= rd_pend_q || !rd_chain;
        end else if (rd_chain) begin
            rd_pend_q <= 1'b0;
        end
    end

    // Output pins are registered on the link clock; strobe alternates per beat.
    // drift is bounded because every beat launches from the same flop stage.
    always_ff @(posedge link_clk or negedge rst_b) begin
        if (!rst_b) begin
            dq_out <= '0;
            dq_oe <= 1'b0;
            dqs_out <= 1'b0;
            dqs_oe <= 1'b0;
        end else begin
            dq_oe <= rd_st_q == BURST;
            dqs_oe <= rd_st_q != IDLE;
            dqs_out <= (rd_st_q == BURST) && !beat_q[0];
            dq_out <= rd_word_q ^ {bank_rw_pkg::DQ_W{beat_q[0]}};
        end
    end

    // Write capture: eight strobe beats with per-byte mask, merged into one word.
    // window opens from write latency.
    logic [3:0] wr_beat_q;
    logic [bank_rw_pkg::DQ_W-1:0] wr_word_q;
    logic wr_done_tog_q;
    logic [bank_rw_pkg::BYTES-1:0] wr_be_q;
    // Bit-wide copy of the byte enables, used by the array update.
    wire [bank_rw_pkg::DQ_W-1:0] wr_bit_en;
    genvar k;
    generate
        for (k = 0; k < bank_rw_pkg::BYTES; k++) begin : g_byte
            // A byte counts as written once any beat carries it unmasked.
            wire take = (wr_beat_q != 4'h0) && !dm_in[k];
            assign wr_bit_en[k*8 +: 8] = {8{wr_be_q[k]}};
            always_ff @(posedge link_clk or negedge rst_b) begin
                if (!rst_b) begin
                    wr_word_q[k*8 +: 8] <= '0;
                    wr_be_q[k] <= 1'b0;
                end else if (wr_start) begin
                    wr_be_q[k] <= 1'b0;
                end else if (take) begin
                    wr_word_q[k*8 +: 8] <= dq_in[k*8 +: 8];
                    wr_be_q[k] <= 1'b1;
                end
            end
        end
    endgenerate
    always_ff @(posedge link_clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_beat_q <= '0;
            wr_done_tog_q <= 1'b0;
        end else if (wr_start) begin
            wr_beat_q <= 4'(bank_rw_pkg::BURST_LEN);
        end else if (wr_beat_q != 4'h0) begin
            wr_beat_q <= wr_beat_q - 4'h1;
            if (wr_beat_q == 4'h1) begin
                wr_done_tog_q <= !wr_done_tog_q;
            end
        end
    end

    // Completed write returns to the core through a toggle synchroniser.
    logic [2:0] done_sync_q;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            done_sync_q <= '0;
        end else begin
            done_sync_q <= {done_sync_q[1:0], wr_done_tog_q};
        end
    end
    wire wr_commit = done_sync_q[2] ^ done_sync_q[1];

    // Array update; the word and enables are stable since the link side finished its burst.
    // Bytes never written in the burst keep what the array held, not the last captured word.
    generate
        for (k = 0; k < bank_rw_pkg::ROW_MEM_DEPTH; k++) begin : g_mem
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    mem_q[k] <= '0;
                end else if (wr_commit && wr_idx_q == bank_rw_pkg::MEM_IDX_W'(k)) begin
                    // masked bytes keep the array value.
                    mem_q[k] <= (wr_word_q & wr_bit_en) | (mem_q[k] & ~wr_bit_en);
                end
            end
        end
    endgenerate

endmodule

// [rtl/bank_rw_pkg.sv]
// Constants shared by the bank, column and data path logic of the memory core.
// Assumes a 25 MHz core clock and a separate link clock for the data strobe side.
package bank_rw_pkg;
    localparam int unsigned CLK_PERIOD_PS = 40000;
    localparam int unsigned NUM_BANKS = 8;
    localparam int unsigned BANK_W = 3;
    localparam int unsigned ROW_W = 15;
    localparam int unsigned COL_W = 10;
    localparam int unsigned CA_W = 10;
    localparam int unsigned DQ_W = 32;
    localparam int unsigned BYTES = 4;
    localparam int unsigned BURST_LEN = 8;
    localparam int unsigned BURST_CYC = 4;
    localparam int unsigned READ_LAT = 6;
    localparam int unsigned WRITE_LAT = 4;
    // Times in picoseconds; tRCD also in core cycles.
    localparam int unsigned T_RCD_PS = 18000;
    localparam int unsigned T_RPRE_PS = 36000;
    localparam int unsigned T_RCD_CYC = (T_RCD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // Command decode positions on the rising-edge word, then array depth and index width.
    localparam int unsigned CA_BIT0 = 0;
    localparam int unsigned CA_BIT1 = 1;
    localparam int unsigned CA_BIT2 = 2;
    localparam int unsigned ROW_MEM_DEPTH = 16;
    localparam int unsigned MEM_IDX_W = 4;
endpackage

// [tb/bank_rw_monitor.sv]
// Assertion checker for the memory core, watching its ports only.
// Assumes it is bound to every bank_rw_core instance.
`timescale 1ns/1ps
module bank_rw_monitor (
    // Clocks and reset.
    input wire logic clk,
    input wire logic rst_b,
    input wire logic link_clk,
    // Command bus.
    input wire logic cs_b,
    input wire logic [9:0] ca,
    // Data pins.
    input wire logic [31:0] dq_in,
    input wire logic [31:0] dq_out,
    input wire logic dq_oe,
    input wire logic [3:0] dm_in,
    input wire logic dqs_out,
    input wire logic dqs_oe,
    // Status.
    input wire logic [7:0] bank_open,
    input wire logic cmd_error,
    input wire logic [31:0] mem_rd_word
);
    // Command decode on the rising-edge word.
    wire act_cmd = !cs_b && !ca[0] && ca[1];
    wire col_cmd = !cs_b && ca[0] && !ca[1];
    wire rd_ok = col_cmd && ca[2] && bank_open[ca[9:7]];
    // A read frame is a low preamble and then eight driven beats.
    sequence s_preamble;
        !dqs_out && !dq_oe;
    endsequence
    sequence s_burst;
        dq_oe [*8];
    endsequence
    a_act_opens_bank: assert property (@(posedge clk) disable iff (!rst_b)
        act_cmd |-> ##2 bank_open[$past(ca[9:7], 2)]) else $error("activate left bank closed");
    a_bank_stays_open: assert property (@(posedge clk) disable iff (!rst_b)
        ($past(bank_open) & ~bank_open) == 8'h00) else $error("open bank closed itself");
    a_refuse_closed: assert property (@(posedge clk) disable iff (!rst_b)
        col_cmd && !bank_open[ca[9:7]] |-> ##[1:2] cmd_error) else $error("closed bank not refused");
    a_err_cause: assert property (@(posedge clk) disable iff (!rst_b)
        $changed(cmd_error) |-> $past(col_cmd) || $past(col_cmd, 2)) else $error("error flag moved alone");
    a_read_starts: assert property (@(posedge clk) disable iff (!rst_b)
        rd_ok |-> ##[6:16] dqs_oe) else $error("read strobe never came");
    a_read_frame: assert property (@(posedge link_clk) disable iff (!rst_b)
        $rose(dqs_oe) |-> s_preamble ##1 s_burst) else $error("bad read frame");
    a_beats_invert: assert property (@(posedge link_clk) disable iff (!rst_b)
        $rose(dq_oe) |=> dq_out == ~$past(dq_out)) else $error("second beat wrong");
    a_data_strobe: assert property (@(posedge link_clk) disable iff (!rst_b)
        dq_oe |-> dqs_oe) else $error("data driven without strobe");
endmodule
bind bank_rw_core bank_rw_monitor u_mon (.clk, .rst_b, .link_clk, .cs_b, .ca, .dq_in, .dq_out, .dq_oe,
    .dm_in, .dqs_out, .dqs_oe, .bank_open, .cmd_error, .mem_rd_word);

// [tb/ctrl_model.sv]
// Controller-side write data driver for the memory core bench.
// Assumes the bench raises wr_go in the cycle carrying a write command.
`timescale 1ns/1ps
module ctrl_model (
    // Clocks and request.
    input wire logic clk,
    input wire logic link_clk,
    input wire logic wr_go,
    input wire logic [31:0] wr_data,
    input wire logic [3:0] wr_mask,
    // Pins toward the core.
    output logic [31:0] dq_in,
    output logic [3:0] dm_in
);
    // data and mask from WL on.
    // The window is wider than a burst since the core's capture phase is hidden.
    initial begin
        dq_in = 32'h0000_0000;
        dm_in = 4'h0;
        forever begin
            @(posedge clk iff wr_go);
            repeat (bank_rw_pkg::WRITE_LAT) @(posedge clk);
            #1;
            dq_in = wr_data;
            dm_in = wr_mask;
            repeat (12) @(posedge link_clk);
            #1;
            dq_in = ~dq_in;
            dm_in = ~dm_in;
        end
    end
endmodule

// [tb/lpddr3_bank_rw_command_timing_tb.sv]
// Self-checking bench: bank state, refusals, masked writes and read bursts.
// Assumes ctrl_model supplies write data and the monitor is bound.
`timescale 1ns/1ps
module lpddr3_bank_rw_command_timing_tb;
    logic clk = 1'b0, link_clk = 1'b0, rst_b = 1'b0, cs_b = 1'b1, wr_go = 1'b0;
    logic [9:0] ca = 10'h000;
    logic [31:0] wr_data = 32'h0000_0000, dq_in, dq_out, mem_rd_word;
    logic [3:0] wr_mask = 4'h0, dm_in;
    logic [7:0] bank_open;
    logic dq_oe, dqs_out, dqs_oe, cmd_error;
    int num_errors = 0, n_compared = 0, seed = 43545, beats = 0;
    // Core clock, and a link clock offset so edges never meet.
    always #20 clk = ~clk;
    initial begin
        #7;
        forever #40 link_clk = ~link_clk;
    end
    always @(posedge link_clk) if (dq_oe === 1'b1) beats++;
    bank_rw_core u_dut (.clk, .rst_b, .cs_b, .ca, .link_clk, .dq_in, .dq_out, .dq_oe, .dm_in, .dqs_out,
        .dqs_oe, .bank_open, .cmd_error, .mem_rd_word);
    ctrl_model u_ctrl (.clk, .link_clk, .wr_go, .wr_data, .wr_mask, .dq_in, .dm_in);
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected word at %0t: %h not %h", $time, got, exp);
        end
    endtask
    task automatic chk_flag(input logic got, input logic exp);
        chk_word({31'h0, got}, {31'h0, exp});
    endtask
    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] m);
        for (int b = 0; b < 4; b++) merge[8*b +: 8] = m[b] ? o[8*b +: 8] : n[8*b +: 8];
    endfunction
    // One command: rising word, then the falling word one cycle later, sampled half a cycle after the rising word.
    task automatic cmd(input logic [9:0] r, input logic [9:0] f, input logic wr);
        @(posedge clk);
        #1 {cs_b, ca, wr_go} = {1'b0, r, wr};
        @(posedge clk);
        #1 {cs_b, ca, wr_go} = {1'b1, f, 1'b0};
        @(posedge clk);
        #1 ca = ~f;
    endtask
    // turnaround gaps kept.
    // Forty cycles after every write and a whole frame after every read.
    task automatic wr(input logic [2:0] bk, input logic [9:0] f, input logic [31:0] d, input logic [3:0] m);
        {wr_data, wr_mask} = {d, m};
        cmd({bk, 4'h0, 3'b001}, f, 1'b1);
        repeat (40) @(posedge clk);
    endtask
    task automatic rd_check(input logic [2:0] bk, input logic [9:0] f, input logic [31:0] exp);
        int n;
        cmd({bk, 4'h0, 3'b101}, f, 1'b0);
        for (n = 0; n < 40 && dq_oe !== 1'b1; n++) begin
            @(posedge link_clk);
            #1;
        end
        chk_word(dq_out, exp);
        chk_flag(dqs_out, 1'b1);
        @(posedge link_clk);
        #1;
        chk_word(dq_out, ~exp);
        chk_flag(dqs_out, 1'b0);
        repeat (10) @(posedge link_clk);
        chk_word(mem_rd_word, exp);
        chk_flag(cmd_error, 1'b0);
    endtask
    task automatic close_out;
        $display("compared %0d, errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // The sequence needs under 3000 core cycles.
    initial begin
        #800000;
        num_errors++;
        $display("unexpected hang at %0t", $time);
        close_out;
    end
    initial begin
        logic [31:0] w1, w2;
        logic [3:0] m;
        logic [9:0] f;
        logic [2:0] bk;
        int b0;
        repeat (6) @(posedge clk);
        #1 rst_b = 1'b1;
        @(posedge clk);
        cmd({3'd3, 4'h0, 3'b101}, 10'h000, 1'b0);
        repeat (3) @(posedge clk);
        #1;
        chk_flag(cmd_error, 1'b1);
        chk_word(beats, 32'h0);
        // no precharge needed.
        // No bank is opened twice or precharged, so those gaps hold trivially.
        // activate spacing kept.
        // Each bank opened once, with a pause after four.
        for (int b = 0; b < 8; b++) begin
            if (b == 4) repeat (8) @(posedge clk);
            cmd({3'(b), 5'($random(seed)), 2'b10}, 10'($random(seed)), 1'b0);
            repeat (2) @(posedge clk);
            #1;
            chk_flag(bank_open[b], 1'b1);
        end
        // Full write, then a masked write over it; the first mask blocks all bytes.
        for (int b = 0; b < 6; b++) begin
            {bk, f, w1, w2} = {3'($random(seed)), 9'($random(seed)), 1'b0, $random(seed), $random(seed)};
            m = (b == 0) ? 4'hf : 4'($random(seed));
            wr(bk, f, w1, 4'h0);
            rd_check(bk, f, w1);
            repeat (10) @(posedge clk);
            wr(bk, f, w2, m);
            rd_check(bk, f, merge(w1, w2, m));
        end
        // A masked write after a write elsewhere keeps the array's own bytes.
        wr(3'd0, 10'h000, w1, 4'h0);
        wr(3'd1, 10'h000, w2, 4'h0);
        wr(3'd0, 10'h000, ~w1, 4'h5);
        rd_check(3'd0, 10'h000, merge(w1, ~w1, 4'h5));
        // Two reads four cycles apart must both deliver a whole burst.
        repeat (20) @(posedge clk);
        b0 = beats;
        cmd({3'd1, 4'h0, 3'b101}, 10'h010, 1'b0);
        repeat (1) @(posedge clk);
        cmd({3'd2, 4'h0, 3'b101}, 10'h020, 1'b0);
        repeat (60) @(posedge clk);
        chk_word(beats - b0, 32'd16);
        close_out;
    end
endmodule
